// ### src/pwm_fault_consts.svh
/*
  Timing figures and input bit positions for the fault and hiccup sequencer.
  Assumes a single core clock whose period is given here in nanoseconds.
*/
`ifndef PWM_FAULT_CONSTS_SVH
`define PWM_FAULT_CONSTS_SVH

`define CLK_PERIOD_NS     50
`define BLANK_TIME_NS     100
`define ONESHOT_TIME_US   50
`define SLEEP_TIME_MS     295

// least times round up, the sleep time rounds down
`define BLANK_CYCLES   ((`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ONESHOT_CYCLES \
  ((`ONESHOT_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_CYCLES   ((`SLEEP_TIME_MS * 1000000) / `CLK_PERIOD_NS)

// positions in the synchronised comparator vector
`define IN_REF_LOW     0
`define IN_OV          1
`define IN_UV          2
`define IN_OC          3
`define IN_PW          4
`define IN_SS_RESET    5
`define IN_SS_OC_THR   6
`define IN_SS_DONE     7
`define IN_GATE_3V     8
`define IN_COUNT       9

`endif

// ### src/pwm_fault_pkg.sv
/*
  Types shared by the fault and hiccup sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pwm_fault_pkg;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_SOFT     = 3'b001,
    ST_RUN      = 3'b010,
    ST_OC_DISCH = 3'b011,
    ST_OC_SHUT  = 3'b100,
    ST_SLEEP    = 3'b101,
    ST_FAULT    = 3'b110
  } seq_state_t;

endpackage

// ### src/blank_if.sv
/*
  Carrier between the sequencer and its leading edge blanking unit.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface blank_if;
  logic gate_rise;
  logic pw_raw;
  logic oc_raw;
  logic pw_ok;
  logic oc_ok;
  logic blanking;

  modport seq
  (
    output gate_rise,
    output pw_raw,
    output oc_raw,
    input  pw_ok,
    input  oc_ok,
    input  blanking
  );

  modport blank
  (
    input  gate_rise,
    input  pw_raw,
    input  oc_raw,
    output pw_ok,
    output oc_ok,
    output blanking
  );
endinterface

// ### src/blanking_timer.sv
/*
  Leading edge blanking: masks both current comparators for a fixed count
  after each drive leading edge.
  Assumes gate_rise is a one-cycle pulse on the core clock.
*/
`timescale 1ns/1ps
`include "pwm_fault_consts.svh"

module blanking_timer
#(
  parameter int BLANK_CYCLES = `BLANK_CYCLES
)
(
  input  wire logic core_clk,
  input  wire logic resetn,
  blank_if.blank    bl
);

  localparam int W = $clog2(BLANK_CYCLES + 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    // the crossing cycle is blanked by gate_rise itself; count the rest
    if (bl.gate_rise)
      cnt_d = W'(BLANK_CYCLES - 1);
    else if (cnt_q != '0)
      cnt_d = cnt_q - 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign bl.blanking = bl.gate_rise | (cnt_q != '0);
  assign bl.pw_ok    = bl.pw_raw & ~bl.blanking;
  assign bl.oc_ok    = bl.oc_raw & ~bl.blanking;

endmodule

// ### src/pwm_fault_hiccup_sequencer.sv
/*
  Protection sequencer of a current mode switching controller: fault
  shutdown, soft-start control, delayed overcurrent hiccup, blanking.
  Assumes analog comparators, the soft-start capacitor and its current
  sources, and the pulse request generator sit outside; all comparator
  outputs arrive asynchronously, the pulse request on the core clock.
*/
// Overview of operation
// - overvoltage forces drive off and a low-power delay of about 295ms.
// - after that delay, restart by soft-start if clear, else shut again.
// - undervoltage shuts down with no low-power state, restarts once clear.
// - overcurrent shutdown path armed only after soft-start completes.
// - armed overcurrent stops soft-start charge, enables 40uA discharge.
// - each overcurrent retriggers a one-shot lasting 50us after it ends.
// - discharge does not revert to charge while the one-shot runs.
// - soft-start down to 4.375V in discharge: drive off, full discharge.
// - after overcurrent shutdown, sleep about 295ms then soft-start.
// - overcurrent gone 50us before 4.375V: resume charging, no shutdown.
// - ignore current sense 100ns per on-pulse, for both comparators.
// - blanking starts at drive rising past 3.0V, not at the request.
// - fault when reference low, overvoltage high or undervoltage low.
// - on fault, drive off at once and discharge soft-start fast.
// - new soft-start only with fault clear and level under reset level.
// - reset level 0.27V; drive stays low until discharged to it.
// - soft-start clamps at 4.5V; overcurrent threshold 0.125V below.
// - soft-start done when its level exceeds the error amplifier.
`timescale 1ns/1ps
`include "pwm_fault_consts.svh"

module pwm_fault_hiccup_sequencer
  import pwm_fault_pkg::*;
#(
  parameter int BLANK_CYCLES   = `BLANK_CYCLES,
  parameter int ONESHOT_CYCLES = `ONESHOT_CYCLES,
  parameter int SLEEP_CYCLES   = `SLEEP_CYCLES
)
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic ref_low_in,
  input  wire logic overvoltage_in,
  input  wire logic undervoltage_in,
  input  wire logic oc_cmp_in,
  input  wire logic pw_cmp_in,
  input  wire logic ss_below_reset_in,
  input  wire logic ss_below_oc_thr_in,
  input  wire logic ss_above_comp_in,
  input  wire logic gate_above_3v_in,
  input  wire logic pwm_request_in,
  output logic      drive_en,
  output logic      ss_charge_en,
  output logic      ss_oc_discharge_en,
  output logic      ss_dump_en,
  output logic      low_power_en,
  output logic      oc_oneshot_active,
  output logic      fault_active
);

  localparam int OS_W = $clog2(ONESHOT_CYCLES + 1);
  localparam int SL_W = $clog2(SLEEP_CYCLES + 1);

  // three-stage synchronisers; a change counts once stages two and three agree
  logic [`IN_COUNT-1:0] raw;
  logic [`IN_COUNT-1:0] s1_q;
  logic [`IN_COUNT-1:0] s2_q;
  logic [`IN_COUNT-1:0] s3_q;
  logic [`IN_COUNT-1:0] in_q;
  logic [`IN_COUNT-1:0] in_d;

  assign raw[`IN_REF_LOW]   = ref_low_in;
  assign raw[`IN_OV]        = overvoltage_in;
  assign raw[`IN_UV]        = undervoltage_in;
  assign raw[`IN_OC]        = oc_cmp_in;
  assign raw[`IN_PW]        = pw_cmp_in;
  assign raw[`IN_SS_RESET]  = ss_below_reset_in;
  assign raw[`IN_SS_OC_THR] = ss_below_oc_thr_in;
  assign raw[`IN_SS_DONE]   = ss_above_comp_in;
  assign raw[`IN_GATE_3V]   = gate_above_3v_in;

  genvar gi;
  generate
    for (gi = 0; gi < `IN_COUNT; gi++)
    begin : g_sync
      always_comb
      begin
        in_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : in_q[gi];
      end
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      in_q <= '0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      in_q <= in_d;
    end
  end

  logic ov;
  logic fault;
  logic ss_at_reset;
  logic ss_at_oc_thr;
  logic ss_done;

  assign ov           = in_q[`IN_OV];
  assign fault        = in_q[`IN_REF_LOW] | ov | in_q[`IN_UV];
  assign ss_at_reset  = in_q[`IN_SS_RESET];
  assign ss_at_oc_thr = in_q[`IN_SS_OC_THR];
  assign ss_done      = in_q[`IN_SS_DONE];

  // leading edge blanking on the drive's own 3.0V crossing
  blank_if bl ();

  logic gate3v_prev_q;
  logic gate3v_prev_d;

  assign gate3v_prev_d = in_q[`IN_GATE_3V];
  assign bl.gate_rise  = in_q[`IN_GATE_3V] & ~gate3v_prev_q;
  assign bl.pw_raw     = in_q[`IN_PW];
  assign bl.oc_raw     = in_q[`IN_OC];

  blanking_timer
  #(
    .BLANK_CYCLES (BLANK_CYCLES)
  )
  u_blank
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .bl       (bl)
  );

  logic oc;
  assign oc = bl.oc_ok;

  // sequencer state and interval counters
  seq_state_t      state_q;
  seq_state_t      state_d;
  logic [OS_W-1:0] os_q;
  logic [OS_W-1:0] os_d;
  logic [SL_W-1:0] sleep_q;
  logic [SL_W-1:0] sleep_d;

  always_comb
  begin
    state_d = state_q;
    os_d    = os_q;
    sleep_d = sleep_q;
    if (os_q != '0)
      os_d = os_q - 1'b1;
    if (sleep_q != '0)
      sleep_d = sleep_q - 1'b1;
    if (oc)
      os_d = OS_W'(ONESHOT_CYCLES);
    case (state_q)
      ST_IDLE:
      begin
        if (fault)
          state_d = ST_FAULT;
        else if (ss_at_reset)
          state_d = ST_SOFT;
      end
      ST_SOFT:
      begin
        if (fault)
          state_d = ST_FAULT;
        else if (ss_done)
          state_d = ST_RUN;
      end
      ST_RUN:
      begin
        if (fault)
          state_d = ST_FAULT;
        else if (oc)
          state_d = ST_OC_DISCH;
      end
      ST_OC_DISCH:
      begin
        if (fault)
          state_d = ST_FAULT;
        else if (ss_at_oc_thr)
          state_d = ST_OC_SHUT;
        else if (os_q == '0 && !oc)
          state_d = ST_RUN;
      end
      ST_OC_SHUT:
      begin
        if (fault)
          state_d = ST_FAULT;
        else if (ss_at_reset)
        begin
          state_d = ST_SLEEP;
          sleep_d = SL_W'(SLEEP_CYCLES);
        end
      end
      ST_SLEEP:
      begin
        if (sleep_q == '0)
          state_d = ST_IDLE;
      end
      ST_FAULT:
      begin
        if (ov)
        begin
          state_d = ST_SLEEP;
          sleep_d = SL_W'(SLEEP_CYCLES);
        end
        else if (!fault)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_q       <= ST_IDLE;
      os_q          <= '0;
      sleep_q       <= '0;
      gate3v_prev_q <= 1'b0;
    end
    else
    begin
      state_q       <= state_d;
      os_q          <= os_d;
      sleep_q       <= sleep_d;
      gate3v_prev_q <= gate3v_prev_d;
    end
  end

  // pulse termination: a qualified trip ends the pulse until the request
  // drops; during soft-start this and the one-shot retrigger are the only overcurrent actions
  logic term_q;
  logic term_d;

  always_comb
  begin
    term_d = term_q;
    if (!pwm_request_in)
      term_d = 1'b0;
    if (bl.pw_ok || oc)
      term_d = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      term_q <= 1'b0;
    else
      term_q <= term_d;
  end

  // registered outputs, computed from the next state so that a fault
  // removes the drive in the cycle it is seen
  logic drive_d;
  logic charge_d;
  logic oc_dis_d;
  logic dump_d;
  logic lp_d;
  logic os_act_d;
  logic fault_d;
  logic drive_allowed;

  always_comb
  begin
    drive_allowed = (state_d == ST_SOFT) || (state_d == ST_RUN) ||
                    (state_d == ST_OC_DISCH);
    drive_d  = drive_allowed && !fault && pwm_request_in &&
               !term_d;
    charge_d = (state_d == ST_SOFT) || (state_d == ST_RUN);
    oc_dis_d = (state_d == ST_OC_DISCH);
    dump_d   = !charge_d && !oc_dis_d;
    lp_d     = (state_d == ST_SLEEP);
    os_act_d = (os_d != '0);
    fault_d  = fault;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      drive_en           <= 1'b0;
      ss_charge_en       <= 1'b0;
      ss_oc_discharge_en <= 1'b0;
      ss_dump_en         <= 1'b1;
      low_power_en       <= 1'b0;
      oc_oneshot_active  <= 1'b0;
      fault_active       <= 1'b0;
    end
    else
    begin
      drive_en           <= drive_d;
      ss_charge_en       <= charge_d;
      ss_oc_discharge_en <= oc_dis_d;
      ss_dump_en         <= dump_d;
      low_power_en       <= lp_d;
      oc_oneshot_active  <= os_act_d;
      fault_active       <= fault_d;
    end
  end

endmodule

// ### testbench/seq_chk.sv
/*
  Port assertions for the fault and hiccup sequencer.
  Assumes one core clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module seq_chk
#(
  parameter int SLEEP_CYCLES   = 50,
  parameter int ONESHOT_CYCLES = 20
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ss_below_reset_in,
  input wire logic ss_above_comp_in,
  input wire logic pwm_request_in,
  input wire logic drive_en,
  input wire logic ss_charge_en,
  input wire logic ss_oc_discharge_en,
  input wire logic ss_dump_en,
  input wire logic low_power_en,
  input wire logic oc_oneshot_active,
  input wire logic fault_active
);
  int   os_len_q;
  int   sl_len_q;
  logic armed_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  always_ff @(posedge core_clk)
  begin
    os_len_q <= (resetn && oc_oneshot_active) ? os_len_q + 1 : 0;
    sl_len_q <= (resetn && low_power_en) ? sl_len_q + 1 : 0;
    armed_q  <= resetn && !ss_dump_en && (armed_q || ss_above_comp_in);
  end

  property p_sleep_off; low_power_en |-> !drive_en && !ss_charge_en;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("drive or charge on while asleep");
  property p_drive_req; drive_en |-> $past(pwm_request_in) && !ss_dump_en;
  endproperty
  a_drive_req: assert property (p_drive_req)
    else $error("drive without request");
  property p_fault_off; fault_active |-> !drive_en; endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("drive on during fault");
  property p_oc_start;
    $rose(ss_oc_discharge_en) |-> $fell(ss_charge_en) && oc_oneshot_active;
  endproperty
  a_oc_start: assert property (p_oc_start)
    else $error("overcurrent discharge start wrong");
  property p_armed; $rose(ss_oc_discharge_en) |-> armed_q; endproperty
  a_armed: assert property (p_armed)
    else $error("overcurrent discharge before soft-start done");
  property p_back; $fell(ss_oc_discharge_en) && ss_charge_en
    |-> !$past(oc_oneshot_active); endproperty
  a_back: assert property (p_back)
    else $error("charge resumed while one-shot active");
  property p_shut; $fell(ss_oc_discharge_en) && !ss_charge_en
    |-> ss_dump_en && !drive_en; endproperty
  a_shut: assert property (p_shut)
    else $error("shutdown without full discharge");
  property p_restart; $rose(ss_charge_en) && $past(ss_dump_en)
    |-> ss_below_reset_in && !fault_active; endproperty
  a_restart: assert property (p_restart)
    else $error("soft-start began above reset level");
  property p_sleep_len; $fell(low_power_en) |-> sl_len_q >= SLEEP_CYCLES;
  endproperty
  a_sleep_len: assert property (p_sleep_len)
    else $error("sleep too short");
  property p_os_len;
    $fell(oc_oneshot_active) |-> os_len_q >= ONESHOT_CYCLES;
  endproperty
  a_os_len: assert property (p_os_len)
    else $error("one-shot too short");
  c_sleep: cover property ($fell(low_power_en));
  c_recover: cover property ($fell(ss_oc_discharge_en) && ss_charge_en);
  c_fault: cover property ($rose(fault_active));
endmodule

bind pwm_fault_hiccup_sequencer seq_chk #(.SLEEP_CYCLES(SLEEP_CYCLES),
  .ONESHOT_CYCLES(ONESHOT_CYCLES)) i_chk (.core_clk(core_clk),
  .resetn(resetn), .ss_below_reset_in(ss_below_reset_in),
  .ss_above_comp_in(ss_above_comp_in), .pwm_request_in(pwm_request_in),
  .drive_en(drive_en), .ss_charge_en(ss_charge_en),
  .ss_oc_discharge_en(ss_oc_discharge_en), .ss_dump_en(ss_dump_en),
  .low_power_en(low_power_en), .oc_oneshot_active(oc_oneshot_active),
  .fault_active(fault_active));

// ### testbench/ss_cap_model.sv
/*
  Soft-start capacitor, its comparators and the gate pin.
  Assumes the sequencer outputs change on the core clock.
*/
`timescale 1ns/1ps
module ss_cap_model
(
  input  wire logic core_clk,
  input  wire logic drive_en,
  input  wire logic ss_charge_en,
  input  wire logic ss_oc_discharge_en,
  input  wire logic ss_dump_en,
  output logic      ss_below_reset_in,
  output logic      ss_below_oc_thr_in,
  output logic      ss_above_comp_in,
  output logic      gate_above_3v_in
);
  // level in 10 mV steps; the slow sink moves one step every 4 cycles
  int         lvl = 0;
  logic [1:0] div = 2'h0;

  initial gate_above_3v_in = 1'b0;
  always @(posedge core_clk)
  begin
    div <= div + 2'h1;
    gate_above_3v_in <= drive_en;
    if (ss_dump_en)
      lvl <= (lvl > 20) ? lvl - 20 : 0;
    else if (ss_oc_discharge_en && div == 2'h3)
      lvl <= lvl - 1;
    else if (ss_charge_en)
      lvl <= (lvl > 445) ? 450 : lvl + 5;
  end

  assign ss_below_reset_in  = lvl < 27;
  assign ss_below_oc_thr_in = lvl < 438;
  assign ss_above_comp_in   = lvl > 300;
endmodule

// ### testbench/pwm_fault_hiccup_sequencer_bench.sv
/*
  Self-checking bench for the fault and hiccup sequencer.
  Assumes ss_cap_model stands in for the analog side.
*/
`timescale 1ns/1ps
module pwm_fault_hiccup_sequencer_bench;
  logic       core_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       ref_low_in = 1'b0;
  logic       overvoltage_in = 1'b0;
  logic       undervoltage_in = 1'b0;
  logic       oc_cmp_in = 1'b0;
  logic       pwm_request_in = 1'b0;
  logic       pw_cmp_in = 1'b0;
  logic       below_rst, below_thr, above_comp, gate_hi;
  logic       drive_en, ss_charge_en, ss_oc_discharge_en, ss_dump_en;
  logic       low_power_en, oc_oneshot_active, fault_active;
  logic [6:0] outs;
  // faults {ref, ov, uv}, low power expected, recovery limit
  logic [11:0] rows [3] = '{12'h828, 12'h578, 12'h228};
  int          errors = 0;
  int          checks = 0;
  int          cyc = 0;

  always #25 core_clk = ~core_clk;
  assign outs = {drive_en, ss_charge_en, ss_oc_discharge_en, ss_dump_en,
                 low_power_en, oc_oneshot_active, fault_active};

  pwm_fault_hiccup_sequencer #(.ONESHOT_CYCLES(20), .SLEEP_CYCLES(50)) i_dut
  (
    .core_clk(core_clk), .resetn(resetn), .ref_low_in(ref_low_in),
    .overvoltage_in(overvoltage_in), .undervoltage_in(undervoltage_in),
    .oc_cmp_in(oc_cmp_in), .pw_cmp_in(pw_cmp_in),
    .ss_below_reset_in(below_rst), .ss_below_oc_thr_in(below_thr),
    .ss_above_comp_in(above_comp), .gate_above_3v_in(gate_hi),
    .pwm_request_in(pwm_request_in), .drive_en(drive_en),
    .ss_charge_en(ss_charge_en), .ss_oc_discharge_en(ss_oc_discharge_en),
    .ss_dump_en(ss_dump_en), .low_power_en(low_power_en),
    .oc_oneshot_active(oc_oneshot_active), .fault_active(fault_active)
  );
  ss_cap_model i_cap
  (
    .core_clk(core_clk), .drive_en(drive_en), .ss_charge_en(ss_charge_en),
    .ss_oc_discharge_en(ss_oc_discharge_en), .ss_dump_en(ss_dump_en),
    .ss_below_reset_in(below_rst), .ss_below_oc_thr_in(below_thr),
    .ss_above_comp_in(above_comp), .gate_above_3v_in(gate_hi)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_bit(input int b, input int lim);
    for (int i = 0; i < lim && outs[b] !== 1'b1; i++)
      @(negedge core_clk);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      test_done();
    end
  end

  initial
  begin
    repeat (10) @(negedge core_clk);
    chk(8'(outs), 8'h08);
    resetn = 1'b1;
    wait_bit(5, 40);
    oc_cmp_in = 1'b1;
    repeat (20) @(negedge core_clk);
    chk({ss_oc_discharge_en, ss_charge_en}, 8'h1);
    oc_cmp_in = 1'b0;
    // let the synchronised trip drain so the termination latch clears
    repeat (6) @(negedge core_clk);
    pwm_request_in = 1'b1;
    repeat (100) @(negedge core_clk);
    $display("start-up test done");
    foreach (rows[i])
    begin
      chk(8'(drive_en), 8'h1);
      {ref_low_in, overvoltage_in, undervoltage_in} = rows[i][11:9];
      repeat (6) @(negedge core_clk);
      chk({drive_en, fault_active, low_power_en}, {6'h1, rows[i][8]});
      {ref_low_in, overvoltage_in, undervoltage_in} = 3'h0;
      wait_bit(5, int'(rows[i][7:0]));
      chk(8'(ss_charge_en), 8'h1);
      repeat (100) @(negedge core_clk);
      $display("fault row %0d done", i);
    end
    pwm_request_in = 1'b0;
    repeat (8) @(negedge core_clk);
    pwm_request_in = 1'b1;
    repeat (2) @(negedge core_clk);
    // spike on both comparators lined up with the gate crossing
    {pw_cmp_in, oc_cmp_in} = 2'h3;
    repeat (2) @(negedge core_clk);
    {pw_cmp_in, oc_cmp_in} = 2'h0;
    repeat (6) @(negedge core_clk);
    chk({drive_en, ss_oc_discharge_en}, 8'h2);
    pw_cmp_in = 1'b1;
    repeat (3) @(negedge core_clk);
    pw_cmp_in = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(8'(drive_en), 8'h0);
    $display("blanking test done");
    pwm_request_in = 1'b0;
    oc_cmp_in = 1'b1;
    repeat (4) @(negedge core_clk);
    oc_cmp_in = 1'b0;
    repeat (8) @(negedge core_clk);
    chk({ss_oc_discharge_en, oc_oneshot_active, ss_charge_en}, 8'h6);
    repeat (40) @(negedge core_clk);
    chk({ss_oc_discharge_en, oc_oneshot_active, ss_charge_en}, 8'h1);
    $display("overcurrent recovery test done");
    oc_cmp_in = 1'b1;
    wait_bit(2, 150);
    chk({low_power_en, drive_en}, 8'h2);
    oc_cmp_in = 1'b0;
    wait_bit(5, 100);
    chk(8'(ss_charge_en), 8'h1);
    $display("overcurrent shutdown test done");
    resetn = 1'b0;
    repeat (10) @(negedge core_clk);
    chk(8'(outs), 8'h08);
    resetn = 1'b1;
    wait_bit(5, 40);
    chk(8'(ss_charge_en), 8'h1);
    $display("mid-run reset test done");
    test_done();
  end
endmodule
